// >>> src/host_csr_pkg.sv
// Constants and carrier types for the host status and indirect access registers.
// Assumes a 16-bit host bus logic block on the same clock that issues single-cycle strobes.
//
// Overview of operation
// - Timer count reads in low half, all ones after reset.
// - Word order all ones: address bit one high selects the low half.
// - Any other word order value: address bit one high selects the high half.
// - Network side FIFO word order never depends on the word order control.
// - 32-bit free tick count clears on reset, steps at 25 MHz, wraps.
// - First half read snapshots the free count; second half reads the snapshot.
// - Free count may take up to 160 ns to read zero after reset.
// - Free count keeps running in every power state.
// - Dropped frame tally counts each discarded frame, zero after reset.
// - Reading the dropped frame tally returns it and then clears it.
// - Tally crossing from 7fffffff to 80000000 raises an event.
// - Writing one to command bit 31 starts the access; zero does nothing.
// - Busy stays set until the access ends; read data valid when busy clears.
// - Command bit 30 picks read when one, write when zero; resets zero.
// - Command bits 7 to 0 pick the MAC register; reset zero.
// - Data register feeds writes and receives read results.
// - Timer counts only while configuration bit 29 is one.
// - Enable falling clears timer preload to all ones.
package host_csr_pkg;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam logic [7:0] OFS_TMR_CFG = 8'h8c;
  localparam logic [7:0] OFS_TMR_CNT = 8'h90;
  localparam logic [7:0] OFS_SWAP    = 8'h98;
  localparam logic [7:0] OFS_FREE    = 8'h9c;
  localparam logic [7:0] OFS_DROP    = 8'ha0;
  localparam logic [7:0] OFS_CMD     = 8'ha4;
  localparam logic [7:0] OFS_DATA    = 8'ha8;

  // ----------------------------------------
  // Field positions and values
  // ----------------------------------------
  localparam int          CMD_BUSY_BIT = 31;
  localparam int          CMD_DIR_BIT  = 30;
  localparam int          TMR_EN_BIT   = 29;
  localparam logic [15:0] TMR_RST      = 16'hffff;
  localparam logic [31:0] SWAP_ALL     = 32'hffffffff;
  localparam logic [31:0] DROP_HALF    = 32'h80000000;
  localparam logic [31:0] WORD_RST     = 32'h00000000;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int          SYS_CLK_MHZ  = 100;
  localparam int          TICK_MHZ     = 25;
  localparam int          TICK_DIV     = SYS_CLK_MHZ / TICK_MHZ;
  localparam logic [1:0]  TICK_LAST    = 2'(TICK_DIV - 1);
  localparam int          FREE_CLR_NS  = 160;
  localparam int          FREE_CLR_CYC = FREE_CLR_NS * SYS_CLK_MHZ / 1000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [7:1] addr;
    logic [15:0] wdata;
  } host_req_t;

  typedef struct packed {
    logic        rnw;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } mac_req_t;

  typedef enum logic {
    MAC_IDLE = 1'b0,
    MAC_BUSY = 1'b1
  } mac_state_t;

endpackage

// >>> src/host_csr.sv
// Host misc status registers: timer view, word order, free tick count,
// dropped frame tally and indirect MAC register access.
// Host strobes are synchronous to i_clk_sys; the MAC side answers with a done pulse.
`timescale 1ns/1ps

module host_csr
  import host_csr_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire host_req_t   i_host,
  input  wire logic        i_frame_drop,
  input  wire logic        i_mac_done,
  input  wire logic [31:0] i_mac_rdata,
  output logic      [15:0] o_rdata,
  output logic             o_rvalid,
  output logic             o_swap_on,
  output logic             o_mac_req,
  output mac_req_t         o_mac_cmd,
  output logic             o_drop_half
);

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [7:0]  word_ofs;
  logic        hi;
  logic        wr;
  logic        rd;
  logic [15:0] wd;

  logic [31:0] swap_q;
  logic        swap_on_q;
  logic [1:0]  div_q;
  logic        tick;
  logic [31:0] free_q;
  logic [31:0] free_snap_q;
  logic        free_armed_q;
  logic [31:0] drop_q;
  logic [31:0] drop_snap_q;
  logic        drop_armed_q;
  logic        drop_clr;
  logic        tmr_en_q;
  logic [15:0] preload_q;
  logic [15:0] tmr_cnt_q;
  mac_state_t  mac_state_q;
  logic        dir_q;
  logic [7:0]  csr_addr_q;
  logic [31:0] data_q;
  logic        start;
  logic [31:0] rd_word;

  assign word_ofs = {i_host.addr[7:2], 2'b00};
  // Registered word order: a new order applies from the access after next
  assign hi       = i_host.addr[1] ^ swap_on_q;
  assign wr       = i_host.cs & i_host.wr;
  assign rd       = i_host.cs & i_host.rd;
  assign wd       = i_host.wdata;

  // ----------------------------------------
  // Word order control
  // ----------------------------------------
  // Only host half placement changes; FIFO network order is fixed elsewhere.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      swap_q <= WORD_RST;
    end else if (wr && word_ofs == OFS_SWAP) begin
      if (hi) begin
        swap_q[31:16] <= wd;
      end else begin
        swap_q[15:0] <= wd;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      swap_on_q <= 1'b0;
    end else begin
      swap_on_q <= (swap_q == SWAP_ALL);
    end
  end

  assign o_swap_on = swap_on_q;

  // ----------------------------------------
  // Free tick count
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      div_q <= 2'h0;
    end else if (tick) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_q + 2'h1;
    end
  end

  assign tick = (div_q == TICK_LAST);

  // No power state input: the count never pauses.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      free_q <= WORD_RST;
    end else if (tick) begin
      free_q <= free_q + 32'h1;
    end
  end

  // Whichever half comes first freezes the whole count.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      free_armed_q <= 1'b0;
      free_snap_q  <= WORD_RST;
    end else if (rd && word_ofs == OFS_FREE) begin
      if (!free_armed_q) begin
        free_snap_q  <= free_q;
        free_armed_q <= 1'b1;
      end else begin
        free_armed_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Dropped frame tally
  // ----------------------------------------
  assign drop_clr = rd && word_ofs == OFS_DROP && !drop_armed_q;

  // A drop in the clearing cycle is kept, so no frame goes uncounted.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      drop_q <= WORD_RST;
    end else if (drop_clr) begin
      drop_q <= {31'h0, i_frame_drop};
    end else if (i_frame_drop) begin
      drop_q <= drop_q + 32'h1;
    end
  end

  // Second half of a read comes from the snapshot taken at the clear.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      drop_armed_q <= 1'b0;
      drop_snap_q  <= WORD_RST;
    end else if (rd && word_ofs == OFS_DROP) begin
      if (!drop_armed_q) begin
        drop_snap_q  <= drop_q;
        drop_armed_q <= 1'b1;
      end else begin
        drop_armed_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_drop_half <= 1'b0;
    end else begin
      o_drop_half <= i_frame_drop && !drop_clr && drop_q == DROP_HALF - 32'h1;
    end
  end

  // ----------------------------------------
  // General purpose timer
  // ----------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tmr_en_q  <= 1'b0;
      preload_q <= TMR_RST;
    end else if (wr && word_ofs == OFS_TMR_CFG) begin
      if (hi) begin
        tmr_en_q <= wd[TMR_EN_BIT-16];
        // Only a falling enable forces the preload; zero written while halted keeps it
        if (tmr_en_q && !wd[TMR_EN_BIT-16]) begin
          preload_q <= TMR_RST;
        end
      end else begin
        preload_q <= wd;
      end
    end
  end

  // Reloads from the preload on start and on each expiry.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tmr_cnt_q <= TMR_RST;
    end else if (wr && word_ofs == OFS_TMR_CFG && hi && wd[TMR_EN_BIT-16] && !tmr_en_q) begin
      tmr_cnt_q <= preload_q;
    end else if (tmr_en_q && tick) begin
      if (tmr_cnt_q == 16'h0) begin
        tmr_cnt_q <= preload_q;
      end else begin
        tmr_cnt_q <= tmr_cnt_q - 16'h1;
      end
    end
  end

  // ----------------------------------------
  // Indirect MAC register access
  // ----------------------------------------
  // Writes while busy are dropped so a running access cannot be corrupted.
  assign start = wr && word_ofs == OFS_CMD && hi && wd[CMD_BUSY_BIT-16]
                 && mac_state_q == MAC_IDLE;

  // Done while idle is ignored, so a stray answer cannot end a later access
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      mac_state_q <= MAC_IDLE;
    end else begin
      case (mac_state_q)
        MAC_IDLE: begin
          if (start) begin
            mac_state_q <= MAC_BUSY;
          end
        end
        MAC_BUSY: begin
          if (i_mac_done) begin
            mac_state_q <= MAC_IDLE;
          end
        end
        default: begin
          mac_state_q <= MAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      dir_q      <= 1'b0;
      csr_addr_q <= 8'h00;
    end else if (wr && word_ofs == OFS_CMD && mac_state_q == MAC_IDLE) begin
      if (hi) begin
        dir_q <= wd[CMD_DIR_BIT-16];
      end else begin
        csr_addr_q <= wd[7:0];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      data_q <= WORD_RST;
    end else if (mac_state_q == MAC_BUSY && i_mac_done && dir_q) begin
      data_q <= i_mac_rdata;
    end else if (wr && word_ofs == OFS_DATA && mac_state_q == MAC_IDLE) begin
      if (hi) begin
        data_q[31:16] <= wd;
      end else begin
        data_q[15:0] <= wd;
      end
    end
  end

  // Direction uses the value of the start write itself; address and data come from csr_addr_q and data_q.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_mac_req <= 1'b0;
      o_mac_cmd <= '0;
    end else begin
      o_mac_req <= start;
      if (start) begin
        o_mac_cmd.rnw   <= wd[CMD_DIR_BIT-16];
        o_mac_cmd.addr  <= csr_addr_q;
        o_mac_cmd.wdata <= data_q;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  always_comb begin
    rd_word = WORD_RST;
    case (word_ofs)
      OFS_TMR_CFG: rd_word = {2'b00, tmr_en_q, 13'h0, preload_q};
      OFS_TMR_CNT: rd_word = {16'h0, tmr_cnt_q};
      OFS_SWAP:    rd_word = swap_q;
      OFS_FREE:    rd_word = free_armed_q ? free_snap_q : free_q;
      OFS_DROP:    rd_word = drop_armed_q ? drop_snap_q : drop_q;
      OFS_CMD:     rd_word = {mac_state_q == MAC_BUSY, dir_q, 22'h0, csr_addr_q};
      OFS_DATA:    rd_word = data_q;
      default:     rd_word = WORD_RST;
    endcase
  end

  // Read data holds between reads so a slow host may take it late
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_rdata  <= 16'h0;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= rd;
      if (rd) begin
        o_rdata <= hi ? rd_word[31:16] : rd_word[15:0];
      end
    end
  end

endmodule

// >>> dv/host_csr_props.sv
// Concurrent checks on the ports of the host status register block.
// Assumes one clock and the synchronous active high reset of the design.
`timescale 1ns/1ps

module host_csr_props
  import host_csr_pkg::*;
(
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire host_req_t   i_host,
  input wire logic        i_frame_drop,
  input wire logic [15:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        o_swap_on,
  input wire logic        o_mac_req,
  input wire mac_req_t    o_mac_cmd,
  input wire logic        o_drop_half
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // ----------------------------------------
  // Host bus steps
  // ----------------------------------------
  sequence s_read;
    i_host.cs && i_host.rd;
  endsequence
  sequence s_top_one;
    i_host.cs && i_host.wr && i_host.wdata[15];
  endsequence
  a_read_answer: assert property (s_read |=> o_rvalid) else $error("no read answer");
  a_rdata_hold: assert property (!(i_host.cs && i_host.rd) |=> $stable(o_rdata) && !o_rvalid)
    else $error("read data moved without read");
  a_start_cause: assert property (o_mac_req |-> $past(i_host.cs && i_host.wr && i_host.wdata[15]))
    else $error("start without busy write");
  a_start_once: assert property (s_top_one ##1 o_mac_req |=> !o_mac_req)
    else $error("start longer than a cycle");
  a_cmd_hold: assert property (!o_mac_req |-> $stable(o_mac_cmd))
    else $error("command moved while idle");
  a_drop_cause: assert property (o_drop_half |-> $past(i_frame_drop))
    else $error("half event without drop");
  a_drop_pulse: assert property (o_drop_half |=> !o_drop_half)
    else $error("half event too long");
  a_swap_cause: assert property ($changed(o_swap_on) |->
    $past(i_host.cs && i_host.wr) || $past(i_host.cs && i_host.wr, 2))
    else $error("word order moved without write");
endmodule

bind host_csr host_csr_props u_props (.i_clk_sys, .i_reset, .i_host, .i_frame_drop, .o_rdata,
  .o_rvalid, .o_swap_on, .o_mac_req, .o_mac_cmd, .o_drop_half);

// >>> dv/mac_side_model.sv
// Behavioural MAC register file answering indirect accesses with a done pulse.
// Assumes one start pulse per access; i_slow picks a long answer time.
`timescale 1ns/1ps

module mac_side_model
  import host_csr_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_reset,
  input  wire logic        i_slow,
  input  wire logic        i_mac_req,
  input  wire mac_req_t    i_mac_cmd,
  output logic             o_done,
  output logic      [31:0] o_rdata
);
  logic [31:0] regs_q [256];
  logic [31:0] last_q;
  logic [3:0]  wait_q;
  mac_req_t    cmd_q;
  // ----------------------------------------
  // Access engine
  // ----------------------------------------
  // Inverted outside done so a stale sample never matches
  assign o_rdata = o_done ? last_q : ~last_q;
  always_ff @(posedge i_clk_sys) begin
    o_done <= 1'b0;
    if (i_reset) begin
      wait_q <= 4'h0;
    end else if (i_mac_req) begin
      wait_q <= i_slow ? 4'h6 : 4'h1;
      cmd_q  <= i_mac_cmd;
    end else if (wait_q == 4'h1) begin
      o_done <= 1'b1;
      wait_q <= 4'h0;
      if (cmd_q.rnw) begin
        last_q <= regs_q[cmd_q.addr];
      end else begin
        regs_q[cmd_q.addr] <= cmd_q.wdata;
      end
    end else if (wait_q != 4'h0) begin
      wait_q <= wait_q - 4'h1;
    end
  end
endmodule

// >>> dv/host_csr_tb.sv
// Self-checking bench for the host status and indirect access registers.
// Assumes the MAC side model and the bound checker are compiled alongside.
`timescale 1ns/1ps

module host_csr_tb;
  import host_csr_pkg::*;
  logic        clk, rst, drop, slow, done, rvalid, swap, mreq, dhalf;
  logic [31:0] mrd;
  logic [15:0] rdata, v, a;
  host_req_t   h;
  mac_req_t    mcmd;
  int          n_errors, checks, cyc;
  logic [7:0]  ro [8] = '{OFS_TMR_CNT, OFS_TMR_CNT, OFS_DROP, OFS_DROP, OFS_CMD, OFS_CMD,
                          OFS_SWAP, 8'h94};

  host_csr dut (.i_clk_sys(clk), .i_reset(rst), .i_host(h), .i_frame_drop(drop),
    .i_mac_done(done), .i_mac_rdata(mrd), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_swap_on(swap), .o_mac_req(mreq), .o_mac_cmd(mcmd), .o_drop_half(dhalf));
  mac_side_model far (.i_clk_sys(clk), .i_reset(rst), .i_slow(slow), .i_mac_req(mreq),
    .i_mac_cmd(mcmd), .o_done(done), .o_rdata(mrd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic acc(logic wr, logic [7:0] ofs, logic a1, logic [15:0] d);
    @(posedge clk); #1;
    h = '{cs: 1'b1, rd: !wr, wr: wr, addr: {ofs[7:2], a1}, wdata: d};
    @(posedge clk); #1;
    h = '0;
    v = rdata;
    if (!wr) chk("rvalid", 32'(rvalid), 32'h1);
  endtask
  task automatic rd(logic [7:0] ofs, logic a1);
    acc(1'b0, ofs, a1, 16'h0);
  endtask
  task automatic wait_idle();
    // Host leaves command and data alone until busy clears
    repeat (20) begin
      rd(OFS_CMD, 1'b1);
      if (v[15] === 1'b0) break;
    end
    chk("busy clear", 32'(v[15]), 32'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset_values();
    for (int i = 0; i < 8; i++) begin
      rd(ro[i], i[0]);
      chk("reset value", 32'(v), (i == 0) ? 32'hffff : 32'h0);
    end
    $display("test reset values done");
  endtask
  task automatic t_free();
    rd(OFS_FREE, 1'b0);
    a = v;
    repeat (40) @(posedge clk);
    rd(OFS_FREE, 1'b0);
    chk("free snapshot", 32'(v), 32'(a));
    rd(OFS_FREE, 1'b0);
    chk("free step", 32'(v), 32'(a + 16'hb));
    rd(OFS_FREE, 1'b1);
    chk("free high", 32'(v), 32'h0);
    $display("test free count done");
  endtask
  task automatic t_drop();
    repeat (3) begin
      @(posedge clk); #1 drop = 1'b1;
      @(posedge clk); #1 drop = 1'b0;
    end
    rd(OFS_DROP, 1'b0);
    chk("tally", 32'(v), 32'h3);
    rd(OFS_DROP, 1'b1);
    rd(OFS_DROP, 1'b0);
    chk("tally cleared", 32'(v), 32'h0);
    rd(OFS_DROP, 1'b1);
    chk("no half event", 32'(dhalf), 32'h0);
    $display("test dropped tally done");
  endtask
  task automatic t_swap();
    acc(1'b1, OFS_SWAP, 1'b0, 16'hffff);
    acc(1'b1, OFS_SWAP, 1'b1, 16'hffff);
    @(posedge clk); #1;
    chk("swap on", 32'(swap), 32'h1);
    rd(OFS_TMR_CNT, 1'b1);
    chk("timer low via a1", 32'(v), 32'hffff);
    acc(1'b1, OFS_SWAP, 1'b0, 16'h1234);
    @(posedge clk); #1;
    chk("swap off", 32'(swap), 32'h0);
    rd(OFS_SWAP, 1'b1);
    chk("word order high", 32'(v), 32'h1234);
    $display("test word order done");
  endtask
  task automatic t_mac();
    acc(1'b1, OFS_DATA, 1'b0, 16'hbeef);
    acc(1'b1, OFS_DATA, 1'b1, 16'hcafe);
    acc(1'b1, OFS_CMD, 1'b0, 16'h005a);
    acc(1'b1, OFS_CMD, 1'b1, 16'h0000);
    chk("no start", 32'(mreq), 32'h0);
    acc(1'b1, OFS_CMD, 1'b1, 16'h8000);
    chk("start", 32'(mreq), 32'h1);
    chk("direction", 32'(mcmd.rnw), 32'h0);
    chk("target", 32'(mcmd.addr), 32'h5a);
    chk("write word", mcmd.wdata, 32'hcafebeef);
    wait_idle();
    acc(1'b1, OFS_DATA, 1'b0, 16'h1111);
    acc(1'b1, OFS_DATA, 1'b1, 16'h2222);
    slow = 1'b1;
    acc(1'b1, OFS_CMD, 1'b1, 16'hc000);
    rd(OFS_CMD, 1'b1);
    chk("busy read", 32'(v), 32'hc000);
    wait_idle();
    rd(OFS_DATA, 1'b0);
    chk("read low", 32'(v), 32'hbeef);
    rd(OFS_DATA, 1'b1);
    chk("read high", 32'(v), 32'hcafe);
    $display("test indirect access done");
  endtask
  task automatic t_timer();
    acc(1'b1, OFS_TMR_CFG, 1'b0, 16'h0100);
    acc(1'b1, OFS_TMR_CFG, 1'b1, 16'h2000);
    repeat (39) @(posedge clk);
    rd(OFS_TMR_CNT, 1'b0);
    chk("timer count", 32'(v), 32'h00f6);
    rd(OFS_TMR_CFG, 1'b1);
    chk("timer enable", 32'(v), 32'h2000);
    acc(1'b1, OFS_TMR_CFG, 1'b1, 16'h0000);
    rd(OFS_TMR_CFG, 1'b0);
    chk("preload forced", 32'(v), 32'hffff);
    rd(OFS_TMR_CNT, 1'b0);
    a = v;
    repeat (20) @(posedge clk);
    rd(OFS_TMR_CNT, 1'b0);
    chk("timer halted", 32'(v), 32'(a));
    $display("test timer done");
  endtask

  initial begin
    rst = 1'b1;
    drop = 1'b0;
    slow = 1'b0;
    h = '0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    t_reset_values();
    t_free();
    t_drop();
    t_swap();
    t_mac();
    t_timer();
    print_verdict();
  end
endmodule
